/* File: hw/fpi_pipe.sv */
/*
  Pipeline side of the FP unit facing the integer unit: fetch capture, dispatch,
  load/store/arith/compare stage sequencing, queue, pipe hold and flush.
  Assumes all inputs are synchronous to core_clk_i and the data bus wire is resolved outside.
*/
`timescale 1ns/100ps
module fpi_pipe #(
  parameter int unsigned QDEPTH = fpi_pkg::Q_DEPTH,
  parameter int unsigned QLAT   = fpi_pkg::Q_LAT
) (
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] data_i,
  output logic      [31:0] data_o,
  output logic             data_oe_o,
  input  wire logic        inst_fetch_i,
  input  wire logic        dispatch_strobe_a_i,
  input  wire logic        dispatch_strobe_b_i,
  input  wire logic        flush_i,
  input  wire logic        memory_data_strobe_n_i,
  input  wire logic        mem_hold_a_n_i,
  input  wire logic        mem_hold_b_n_i,
  input  wire logic        bus_hold_n_i,
  input  wire logic        copro_hold_n_i,
  input  wire logic        copro_cond_valid_i,
  output logic             fpu_pipe_hold_n_o,
  output logic             fp_cond_valid_o,
  output logic      [1:0]  fp_cond_codes_o,
  output logic             fp_exc_o
);
  import fpi_pkg::*;

  localparam int unsigned CW = $clog2(QDEPTH + 1);
  localparam int unsigned LW = $clog2(QLAT + 1);

  // ==========================================================================
  // State
  fpi_pair_t   buf_q;
  logic [31:0] addr_prev_q, status_q, opa_q, opb_q, ld_hi_q, ld_lo_q, dout_q;
  logic        buf_vld_q, fetch_seen_q, w_first_q, hold_n_q, ccv_q, exc_q, doe_q, q_exc_q;
  logic [1:0]  fcc_q;
  logic [LW-1:0] lat_q;
  fpi_stage_t  e_q, w_q, h1_q, h2_q, e_d, w_d, h1_d, h2_d;
  fpi_cmp_t    cmp_q, cmp_d;
  fpi_kind_t   buf_kind, hold_kind;

  // ==========================================================================
  // Hold and dispatch qualification
  wire logic mem_hold = !mem_hold_a_n_i || !mem_hold_b_n_i || !bus_hold_n_i;
  wire logic hold_any = mem_hold || !copro_hold_n_i || !hold_n_q || !ccv_q || !copro_cond_valid_i;
  wire logic advance  = !hold_any;
  // Either strobe launches; both at once never happens, so a plain OR is enough
  wire logic strobe   = dispatch_strobe_a_i || dispatch_strobe_b_i;
  wire logic accept   = strobe && buf_vld_q && !flush_i && !hold_any;
  wire logic refill   = !memory_data_strobe_n_i && fetch_seen_q;

  assign buf_kind = fpi_decode(buf_q.instr);

  // ==========================================================================
  // Stage movement; flush empties every stage not yet queued
  wire logic w_is_mem = w_q.vld && (w_q.kind != K_NONE) && (w_q.kind < K_CMP);
  wire logic h1_two   = h1_q.vld && (h1_q.kind == K_LDD || h1_q.kind == K_STD || h1_q.kind == K_STQ);
  wire logic w_arith  = w_q.vld && (w_q.kind == K_ARITH);
  wire logic q_push   = w_arith && w_first_q && !flush_i;

  assign e_d  = flush_i ? STAGE_IDLE : accept ? fpi_stage_t'{1'b1, buf_kind, buf_q}
              : advance ? STAGE_IDLE : e_q;
  assign w_d  = flush_i ? STAGE_IDLE : advance ? e_q : q_push ? STAGE_IDLE : w_q;
  assign h1_d = flush_i ? STAGE_IDLE : advance ? (w_is_mem ? w_q : STAGE_IDLE) : h1_q;
  assign h2_d = flush_i ? STAGE_IDLE : advance ? (h1_two ? h1_q : STAGE_IDLE) : h2_q;

  // ==========================================================================
  // Register file read: addresses follow the instruction now in or entering E
  fpi_stage_t  rd_src;
  logic [31:0] rs_ins, ra_data, rb_data;
  logic [REG_AW-1:0] ra_addr, rb_addr;
  wire logic   rd_store = rd_src.kind inside {K_STS, K_STD};
  assign rd_src  = accept ? e_d : e_q;
  assign rs_ins  = rd_src.pair.instr;
  assign ra_addr = rd_store ? {rs_ins[RD_LO+1 +: REG_AW-1], rs_ins[RD_LO] & (rd_src.kind == K_STS)}
                 : rs_ins[RS1_LO +: REG_AW];
  assign rb_addr = rd_store ? {rs_ins[RD_LO+1 +: REG_AW-1], 1'b1} : rs_ins[RS2_LO +: REG_AW];

  // ==========================================================================
  // Queue execution runs on its own; pipe holds do not reach it
  fpi_qent_t   q_head;
  logic [CW-1:0] q_count;
  logic        q_empty;
  wire logic [8:0] q_opf = q_head.pair.instr[OPF_LO +: 9];
  wire logic   q_run    = !q_empty && !q_exc_q;
  wire logic   q_done   = q_run && (lat_q == LW'(QLAT));
  wire logic   q_unimp  = !(q_opf == OPF_MOV || q_opf == OPF_NEG || q_opf == OPF_ABS);
  wire logic   ld_w1    = h1_q.vld && h1_q.kind == K_LDS && !flush_i;
  wire logic   ld_w2    = h2_q.vld && h2_q.kind == K_LDD && !flush_i;
  wire logic   stq_pop  = advance && h1_q.vld && h1_q.kind == K_STQ && !flush_i;
  // A queued result waits a cycle rather than fight a load for the write port
  wire logic   q_ok     = q_done && !q_unimp && !ld_w1 && !ld_w2 && !stq_pop;
  wire logic   q_pop    = q_ok || stq_pop;
  wire logic   q_exc_d  = (q_done && q_unimp) || (q_exc_q && !q_empty);
  wire logic [31:0] q_res = (q_opf == OPF_NEG) ? {~q_head.opb[31], q_head.opb[30:0]}
                          : (q_opf == OPF_ABS) ? {1'b0, q_head.opb[30:0]} : q_head.opb;

  wire logic [REG_AW-1:0] ld_rd = h2_q.vld ? {h2_q.pair.instr[RD_LO+1 +: REG_AW-1], 1'b0}
                                  : h1_q.pair.instr[RD_LO +: REG_AW];
  wire logic [REG_AW-1:0] q_rd  = q_head.pair.instr[RD_LO +: REG_AW];

  fpi_queue #(
    .W     ($bits(fpi_qent_t)),
    .DEPTH (QDEPTH)
  ) u_queue (
    .clk_i   (core_clk_i),
    .rstn_i  (rstn_i),
    .push_i  (q_push),
    .data_i  (fpi_qent_t'{w_q.pair, opb_q}),
    .pop_i   (q_pop),
    .head_o  (q_head),
    .count_o (q_count),
    .empty_o (q_empty)
  );

  fpi_regfile #(
    .AW (REG_AW),
    .DW (32)
  ) u_regs (
    .clk_i     (core_clk_i),
    .ra_addr_i (ra_addr),
    .rb_addr_i (rb_addr),
    .ra_data_o (ra_data),
    .rb_data_o (rb_data),
    .wa_en_i   (ld_w1 || ld_w2 || q_ok),
    .wa_addr_i (q_ok ? q_rd : ld_rd),
    .wa_data_i (q_ok ? q_res : ld_hi_q),
    .wb_en_i   (ld_w2),
    .wb_addr_i ({ld_rd[REG_AW-1:1], 1'b1}),
    .wb_data_i (ld_lo_q)
  );

  // ==========================================================================
  // Pipe hold: queue-full and queue-empty checks on the instruction in or entering E
  wire logic w_pend = w_arith && w_first_q;
  wire logic short  = (int'(q_count) + int'(w_pend)) >= int'(QDEPTH);
  // Exception mode drops the hold, otherwise a stuck queue would lock the pipe
  wire logic dep    = !q_exc_q && (((hold_kind == K_ARITH) && short)
                    || ((hold_kind == K_LDST || hold_kind == K_STST) && (!q_empty || w_pend)));
  assign hold_kind  = accept ? buf_kind : e_q.vld ? e_q.kind : K_NONE;

  // ==========================================================================
  // Compare sequencing
  wire logic [8:0] e_opf   = e_q.pair.instr[OPF_LO +: 9];
  wire logic cmp_start     = advance && e_q.vld && e_q.kind == K_CMP && !flush_i;
  wire logic cmp_impl      = (e_opf == OPF_CMP) || (e_opf == OPF_CMPE);
  wire logic sgn_diff      = opa_q[31] != opb_q[31];
  wire logic mag_lt        = opa_q[31] ? (opa_q[30:0] > opb_q[30:0]) : (opa_q[30:0] < opb_q[30:0]);
  wire logic cmp_lt        = sgn_diff ? opa_q[31] : mag_lt;
  wire logic [1:0] cmp_res = (opa_q == opb_q) ? FCC_EQ : cmp_lt ? FCC_LT : FCC_GT;

  always_comb begin
    cmp_d = cmp_q;
    case (cmp_q)
      CMP_IDLE: begin
        if (cmp_start) begin
          cmp_d = cmp_impl ? CMP_CALC : CMP_TRAP;
        end
      end
      CMP_CALC: begin
        cmp_d = flush_i ? CMP_IDLE : CMP_POST;
      end
      CMP_POST: begin
        cmp_d = CMP_IDLE;
      end
      CMP_TRAP: begin
        if (flush_i) begin
          cmp_d = CMP_IDLE;
        end
      end
      default: begin
        cmp_d = CMP_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // Data bus drive for stores; the mid-cycle switch points map onto clock edges
  wire logic st_first  = advance && !flush_i && e_q.vld && (e_q.kind inside {K_STS, K_STD, K_STST, K_STQ});
  wire logic st_second = advance && !flush_i && w_q.vld && (w_q.kind == K_STD || w_q.kind == K_STQ);
  wire logic [31:0] status_rd = {status_q[31:ST_QNE+1], !q_empty, status_q[ST_QNE-1:0]};
  wire logic [31:0] first_w   = (e_q.kind == K_STST) ? status_rd
                              : (e_q.kind == K_STQ) ? q_head.pair.addr : ra_data;
  wire logic [31:0] second_w  = (w_q.kind == K_STQ) ? q_head.pair.instr : opb_q;
  wire logic        doe_d     = flush_i ? 1'b0 : advance ? (st_first || st_second) : doe_q;

  // ==========================================================================
  // Fetch capture
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      addr_prev_q  <= '0;
      buf_q        <= '0;
      buf_vld_q    <= 1'b0;
      fetch_seen_q <= 1'b0;
    end else begin
      addr_prev_q <= addr_i;
      if (!mem_hold) begin
        fetch_seen_q <= inst_fetch_i;
      end
      if (inst_fetch_i) begin
        buf_q     <= fpi_pair_t'{addr_prev_q, data_i};
        buf_vld_q <= 1'b1;
      end else if (refill) begin
        buf_q.instr <= data_i;
        buf_vld_q   <= 1'b1;
      end else if (mem_hold && fetch_seen_q) begin
        buf_vld_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Pipeline stages and operand capture
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      e_q       <= STAGE_IDLE;
      w_q       <= STAGE_IDLE;
      h1_q      <= STAGE_IDLE;
      h2_q      <= STAGE_IDLE;
      w_first_q <= 1'b0;
      opa_q     <= '0;
      opb_q     <= '0;
      ld_hi_q   <= '0;
      ld_lo_q   <= '0;
    end else begin
      e_q       <= e_d;
      w_q       <= w_d;
      h1_q      <= h1_d;
      h2_q      <= h2_d;
      w_first_q <= advance && e_q.vld && !flush_i;
      if (advance) begin
        opa_q <= ra_data;
        opb_q <= rb_data;
      end
      if (w_q.vld && (w_q.kind inside {K_LDS, K_LDD, K_LDST})) begin
        ld_hi_q <= data_i;
      end
      if (h1_q.vld && h1_q.kind == K_LDD) begin
        ld_lo_q <= data_i;
      end
    end
  end

  // ==========================================================================
  // Queue latency, status register and handshake outputs
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lat_q    <= '0;
      q_exc_q  <= 1'b0;
      status_q <= ST_RESET;
      cmp_q    <= CMP_IDLE;
      fcc_q    <= FCC_EQ;
      ccv_q    <= 1'b1;
      hold_n_q <= 1'b1;
      exc_q    <= 1'b0;
      doe_q    <= 1'b0;
      dout_q   <= '0;
    end else begin
      lat_q   <= (!q_run || q_pop) ? '0 : (q_done ? lat_q : LW'(lat_q + 1'b1));
      q_exc_q <= q_exc_d;
      cmp_q   <= cmp_d;
      ccv_q   <= (cmp_d == CMP_IDLE);
      if (cmp_q == CMP_CALC && !flush_i) begin
        fcc_q <= cmp_res;
      end
      if (h1_q.vld && h1_q.kind == K_LDST && !flush_i) begin
        status_q <= ld_hi_q;
      end else if (cmp_q == CMP_POST && !flush_i) begin
        status_q[ST_FCC_LO +: 2] <= fcc_q;
      end else if (q_done && q_unimp) begin
        status_q[ST_TT_LO +: 3] <= TT_UNIMP;
      end
      hold_n_q <= !(dep && !flush_i);
      exc_q    <= q_exc_d || (cmp_d == CMP_TRAP);
      doe_q    <= doe_d;
      if (st_first) begin
        dout_q <= first_w;
      end else if (st_second) begin
        dout_q <= second_w;
      end
    end
  end

  assign data_o            = dout_q;
  assign data_oe_o         = doe_q;
  assign fpu_pipe_hold_n_o = hold_n_q;
  assign fp_cond_valid_o   = ccv_q;
  assign fp_cond_codes_o   = fcc_q;
  assign fp_exc_o          = exc_q;
endmodule

/* File: hw/fpi_pkg.sv */
/*
  Shared constants, types and the instruction classifier for the FP pipeline interface.
  Assumes one system clock shared with the integer unit and a fixed 32-bit instruction field layout.
*/
package fpi_pkg;

  // ==========================================================================
  // Sizes and timing
  localparam int unsigned Q_DEPTH = 4;
  localparam int unsigned Q_LAT   = 3;
  localparam int unsigned REG_AW  = 5;

  // ==========================================================================
  // Instruction fields and opcodes
  localparam int unsigned   OP3_LO = 19;
  localparam int unsigned   RD_LO  = 25;
  localparam int unsigned   RS1_LO = 14;
  localparam int unsigned   RS2_LO = 0;
  localparam int unsigned   OPF_LO = 5;
  localparam logic [1:0]    OP_MEM = 2'h3;
  localparam logic [1:0]    OP_ALU = 2'h2;
  localparam logic [5:0]    OP3_LDS = 6'h20, OP3_LDST = 6'h21, OP3_LDD = 6'h23;
  localparam logic [5:0]    OP3_STS = 6'h24, OP3_STST = 6'h25, OP3_STQ = 6'h26, OP3_STD = 6'h27;
  localparam logic [5:0]    OP3_ARITH = 6'h34, OP3_CMP = 6'h35;
  localparam logic [8:0]    OPF_MOV = 9'h001, OPF_NEG = 9'h005, OPF_ABS = 9'h009;
  localparam logic [8:0]    OPF_CMP = 9'h051, OPF_CMPE = 9'h055;

  // ==========================================================================
  // Status register layout
  localparam int unsigned   ST_FCC_LO = 10;
  localparam int unsigned   ST_QNE    = 13;
  localparam int unsigned   ST_TT_LO  = 14;
  localparam logic [31:0]   ST_RESET  = 32'h0000_0000;
  localparam logic [2:0]    TT_UNIMP  = 3'h3;
  localparam logic [1:0]    FCC_EQ = 2'h0, FCC_LT = 2'h1, FCC_GT = 2'h2;

  // ==========================================================================
  // Types
  typedef enum logic [3:0] {
    K_NONE = 4'h0, K_LDS = 4'h1, K_LDD = 4'h2, K_LDST = 4'h3, K_STS = 4'h4,
    K_STD = 4'h5, K_STST = 4'h6, K_STQ = 4'h7, K_CMP = 4'h8, K_ARITH = 4'h9
  } fpi_kind_t;

  typedef enum logic [1:0] {
    CMP_IDLE = 2'h0, CMP_CALC = 2'h1, CMP_POST = 2'h2, CMP_TRAP = 2'h3
  } fpi_cmp_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] instr;
  } fpi_pair_t;

  typedef struct packed {
    logic      vld;
    fpi_kind_t kind;
    fpi_pair_t pair;
  } fpi_stage_t;

  typedef struct packed {
    fpi_pair_t   pair;
    logic [31:0] opb;
  } fpi_qent_t;

  localparam fpi_stage_t STAGE_IDLE = '0;

  function automatic fpi_kind_t fpi_decode(input logic [31:0] ins);
    logic [5:0] op3;
    fpi_kind_t  k;
    op3 = ins[OP3_LO +: 6];
    k   = K_NONE;
    if (ins[31:30] == OP_MEM) begin
      case (op3)
        OP3_LDS:  k = K_LDS;
        OP3_LDD:  k = K_LDD;
        OP3_LDST: k = K_LDST;
        OP3_STS:  k = K_STS;
        OP3_STD:  k = K_STD;
        OP3_STST: k = K_STST;
        OP3_STQ:  k = K_STQ;
        default:  k = K_NONE;
      endcase
    end else if (ins[31:30] == OP_ALU && op3 == OP3_ARITH) begin
      k = K_ARITH;
    end else if (ins[31:30] == OP_ALU && op3 == OP3_CMP) begin
      k = K_CMP;
    end
    return k;
  endfunction

endpackage

/* File: hw/fpi_regfile.sv */
/*
  Floating-point register file: two registered read ports, two write ports.
  Assumes callers never need read-during-write bypass; port b wins on a shared address.
*/
`timescale 1ns/100ps
module fpi_regfile #(
  parameter int unsigned AW = 5,
  parameter int unsigned DW = 32
) (
  input  wire logic          clk_i,
  input  wire logic [AW-1:0] ra_addr_i,
  input  wire logic [AW-1:0] rb_addr_i,
  output logic      [DW-1:0] ra_data_o,
  output logic      [DW-1:0] rb_data_o,
  input  wire logic          wa_en_i,
  input  wire logic [AW-1:0] wa_addr_i,
  input  wire logic [DW-1:0] wa_data_i,
  input  wire logic          wb_en_i,
  input  wire logic [AW-1:0] wb_addr_i,
  input  wire logic [DW-1:0] wb_data_i
);
  logic [DW-1:0] mem_q [2**AW];

  // ==========================================================================
  // Storage
  always_ff @(posedge clk_i) begin
    ra_data_o <= mem_q[ra_addr_i];
    rb_data_o <= mem_q[rb_addr_i];
    if (wa_en_i) begin
      mem_q[wa_addr_i] <= wa_data_i;
    end
    if (wb_en_i) begin
      mem_q[wb_addr_i] <= wb_data_i;
    end
  end
endmodule

/* File: hw/fpi_queue.sv */
/*
  FP queue: in-order store of operations under execution.
  Assumes the owner never pushes when full; the pipe hold prevents it.
*/
`timescale 1ns/100ps
module fpi_queue #(
  parameter int unsigned W     = 96,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic                         clk_i,
  input  wire logic                         rstn_i,
  input  wire logic                         push_i,
  input  wire logic [W-1:0]                 data_i,
  input  wire logic                         pop_i,
  output logic      [W-1:0]                 head_o,
  output logic      [$clog2(DEPTH+1)-1:0]   count_o,
  output logic                              empty_o
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);
  logic [W-1:0]  ent_q [DEPTH];
  logic [PW-1:0] rd_q, wr_q;
  logic [CW-1:0] cnt_q;
  wire logic     do_push = push_i && (cnt_q != CW'(DEPTH));
  wire logic     do_pop  = pop_i && (cnt_q != '0);

  assign head_o  = ent_q[rd_q];
  assign count_o = cnt_q;
  assign empty_o = (cnt_q == '0);

  // ==========================================================================
  // Pointers wrap explicitly so any depth works
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_q  <= '0;
      wr_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : PW'(wr_q + 1'b1);
      end
      if (do_pop) begin
        rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : PW'(rd_q + 1'b1);
      end
      cnt_q <= CW'(cnt_q + CW'(do_push) - CW'(do_pop));
    end
  end

  always_ff @(posedge clk_i) begin
    if (do_push) begin
      ent_q[wr_q] <= data_i;
    end
  end
endmodule

/* File: verification/fpi_pipe_sva.sv */
/* Port-level timing checks for fpi_pipe.
   Assumes the bind below and one clock domain. */
`timescale 1ns/100ps
module fpi_pipe_sva (
  input wire logic       core_clk_i,
  input wire logic       rstn_i,
  input wire logic       flush_i,
  input wire logic       data_oe_o,
  input wire logic       fpu_pipe_hold_n_o,
  input wire logic       fp_cond_valid_o,
  input wire logic [1:0] fp_cond_codes_o,
  input wire logic       fp_exc_o
);
  // ==========
  // Properties
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  a_flush_bus_off: assert property (flush_i |=> !data_oe_o) else $error("bus kept");
  a_store_no_flush: assert property ($rose(data_oe_o) |-> !$past(flush_i)) else $error("flushed drive");
  a_cmp_flush_back: assert property (flush_i && !fp_cond_valid_o |=> fp_cond_valid_o) else $error("cv");
  a_cmp_low_two: assert property ($fell(fp_cond_valid_o) && !flush_i |=> !fp_cond_valid_o ##1
    (fp_cond_valid_o || fp_exc_o)) else $error("cv width");
  a_codes_lead_valid: assert property ($rose(fp_cond_valid_o) && !$past(flush_i) |->
    $stable(fp_cond_codes_o)) else $error("cc late");
  a_unimp_freeze: assert property (fp_exc_o && !fp_cond_valid_o && !flush_i |=> !fp_cond_valid_o)
    else $error("freeze");
  a_exc_hold_free: assert property (fp_exc_o && $past(fp_exc_o) |-> fpu_pipe_hold_n_o) else $error("hold");
  a_hold_flush_off: assert property (!fpu_pipe_hold_n_o && flush_i |=> fpu_pipe_hold_n_o) else $error("hf");
  c_cmp: cover property ($fell(fp_cond_valid_o));
  c_store: cover property ($rose(data_oe_o));
  c_hold: cover property ($fell(fpu_pipe_hold_n_o));
endmodule

bind fpi_pipe fpi_pipe_sva u_sva (.core_clk_i, .rstn_i, .flush_i, .data_oe_o, .fpu_pipe_hold_n_o,
  .fp_cond_valid_o, .fp_cond_codes_o, .fp_exc_o);

/* File: verification/fpi_mem_model.sv */
/* Memory side of the shared data bus.
   Assumes the bench says when memory drives and with what word. */
`timescale 1ns/100ps
module fpi_mem_model (
  input  wire logic        clk_i,
  input  wire logic        oe_i,
  input  wire logic [31:0] dev_i,
  input  wire logic        drv_i,
  input  wire logic [31:0] word_i,
  output logic      [31:0] bus_o
);
  // ==========
  // Bus
  logic [31:0] last_q = 32'h0;
  // Released bus toggles so a stale word never passes as fresh
  assign bus_o = oe_i ? dev_i : drv_i ? word_i : ~last_q;
  always @(posedge clk_i) last_q <= bus_o;
endmodule

/* File: verification/fpi_tb.sv */
/* Self-checking bench for fpi_pipe.
   Assumes QDEPTH 2 and a long queue latency so the queue fills within a few launches. */
`timescale 1ns/100ps
module tb;
  import fpi_pkg::*;
  // ==========
  // Signals
  logic        core_clk_i = 0, rstn_i = 0, inst_fetch_i = 0, fl = 0, drv = 0, sel;
  logic        dispatch_strobe_a_i = 0, dispatch_strobe_b_i = 0, memory_data_strobe_n_i = 1;
  logic [31:0] addr_i = 0, word = 0, miss = 0, v[3], data_i, data_o;
  logic [5:0]  blk = 0;
  logic [1:0]  fp_cond_codes_o;
  logic        data_oe_o, fpu_pipe_hold_n_o, fp_cond_valid_o, fp_exc_o;
  wire logic   flush_i = fl | blk[5];
  wire logic   mem_hold_a_n_i = !blk[0], mem_hold_b_n_i = !blk[1], bus_hold_n_i = !blk[2];
  wire logic   copro_hold_n_i = !blk[3], copro_cond_valid_i = !blk[4];
  int          err_count = 0, samples_checked = 0, cyc = 0, seed = 32'h2deb;
  always #10 core_clk_i = ~core_clk_i;
  fpi_pipe #(.QDEPTH(2), .QLAT(12)) u_dut (.core_clk_i, .rstn_i, .addr_i, .data_i, .data_o, .data_oe_o, .inst_fetch_i,
    .dispatch_strobe_a_i, .dispatch_strobe_b_i, .flush_i, .memory_data_strobe_n_i, .mem_hold_a_n_i,
    .mem_hold_b_n_i, .bus_hold_n_i, .copro_hold_n_i, .copro_cond_valid_i, .fpu_pipe_hold_n_o,
    .fp_cond_valid_o, .fp_cond_codes_o, .fp_exc_o);
  fpi_mem_model u_mem (.clk_i(core_clk_i), .oe_i(data_oe_o), .dev_i(data_o), .drv_i(drv), .word_i(word),
    .bus_o(data_i));
  // ==========
  // Helpers
  task automatic chk(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [31:0] mk(input logic [5:0] op3, input logic [4:0] rd, rs1, input logic [8:0] opf,
                                     input logic [4:0] rs2);
    return {(op3[4] ? OP_ALU : OP_MEM), rd, op3, rs1, opf, rs2};
  endfunction
  function automatic logic [1:0] cc(input logic [31:0] a, b);
    if (a == b) return FCC_EQ;
    if (a[31] != b[31]) return a[31] ? FCC_LT : FCC_GT;
    return ((a[30:0] < b[30:0]) ^ a[31]) ? FCC_LT : FCC_GT;
  endfunction
  // Miss path: garbage first, then refill under a memory hold
  task automatic fetch(input logic [31:0] ins);
    @(negedge core_clk_i) addr_i = $random(seed);
    @(negedge core_clk_i) {inst_fetch_i, drv, word} = {2'h3, (miss != 0) ? miss : ins};
    if (miss != 0) begin
      @(negedge core_clk_i) {inst_fetch_i, drv, blk} = 8'h01;
      @(negedge core_clk_i) {memory_data_strobe_n_i, drv, word} = {2'h1, ins};
      @(negedge core_clk_i) {memory_data_strobe_n_i, drv, blk} = 8'h80;
    end
  endtask
  task automatic launch(input logic [5:0] b);
    sel = $random(seed);
    @(negedge core_clk_i) {inst_fetch_i, drv, blk, dispatch_strobe_a_i, dispatch_strobe_b_i} = {2'h0, b, sel, !sel};
    @(negedge core_clk_i) {blk, dispatch_strobe_a_i, dispatch_strobe_b_i} = '0;
  endtask
  task automatic load(input logic [4:0] rd, input logic [31:0] val, input logic f);
    fetch(mk(OP3_LDS, rd, '0, '0, '0));
    launch('0);
    @(negedge core_clk_i) {drv, word, fl} = {1'b1, val, f};
    @(negedge core_clk_i) {drv, fl} = '0;
    repeat (2) @(negedge core_clk_i);
  endtask
  task automatic store(input logic [5:0] op3, input logic [4:0] rs, input logic [31:0] hi, lo,
                       input logic f, input logic [5:0] b);
    logic d;
    d = (op3 == OP3_STD) && !f && b == 0;
    fetch(mk(op3, rs, '0, '0, '0));
    launch(b);
    @(negedge core_clk_i) fl = f;
    chk(data_oe_o, b == 0);
    if (b == 0) chk(data_o, hi);
    @(negedge core_clk_i) fl = 0;
    chk(data_oe_o, d);
    if (d) chk(data_o, lo);
    @(negedge core_clk_i) chk(data_oe_o, 0);
  endtask
  task automatic cmp(input logic [4:0] a, b, input logic [8:0] opf);
    fetch(mk(OP3_CMP, '0, a, opf, b));
    launch('0);
    @(negedge core_clk_i) chk(fp_cond_valid_o, 0);
    if (opf == OPF_CMP) begin
      @(negedge core_clk_i) chk(fp_cond_codes_o, cc(v[a], v[b]));
      @(negedge core_clk_i) chk(fp_cond_valid_o, 1);
    end else begin
      repeat (3) @(negedge core_clk_i);
      chk({fp_exc_o, fp_cond_valid_o}, 2'h2);
      fl = 1;
      @(negedge core_clk_i) fl = 0;
      chk(fp_cond_valid_o, 1);
    end
  endtask
  task automatic wait_hold(input logic e);
    int n = 0;
    while (fpu_pipe_hold_n_o !== e && n < 30) begin
      @(negedge core_clk_i);
      n++;
    end
    chk(fpu_pipe_hold_n_o, e);
  endtask
  // ==========
  // Sequence
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    for (int i = 0; i < 3; i++) v[i] = $random(seed);
    repeat (4) @(negedge core_clk_i);
    rstn_i = 1;
    @(negedge core_clk_i) chk({fp_exc_o, data_oe_o, fp_cond_valid_o, fpu_pipe_hold_n_o}, 4'h3);
    for (int i = 0; i < 3; i++) load(5'(i), v[i], 0);
    load(5'h1, ~v[1], 1);
    store(OP3_STS, 5'h1, v[1], 0, 0, 0);
    store(OP3_STD, 5'h0, v[0], v[1], 0, 0);
    store(OP3_STD, 5'h0, v[0], 0, 1, 0);
    for (int i = 0; i < 6; i++) store(OP3_STS, 5'h1, 0, 0, 0, 6'h1 << i);
    miss = mk(OP3_STS, 5'h2, '0, '0, '0);
    store(OP3_STS, 5'h1, v[1], 0, 0, 0);
    miss = 0;
    cmp(5'h1, 5'h2, OPF_CMP);
    cmp(5'h2, 5'h1, OPF_CMP);
    cmp(5'h1, 5'h1, OPF_CMP);
    for (int r = 0; r < 2; r++) begin
      repeat (3) begin
        fetch(mk(OP3_ARITH, 5'h4, '0, OPF_MOV, 5'h1));
        launch('0);
      end
      wait_hold(0);
      if (r == 0) wait_hold(1);
    end
    fl = 1;
    @(negedge core_clk_i) fl = 0;
    chk(fpu_pipe_hold_n_o, 1);
    // Two queued operations of the long latency must drain before the store reads
    repeat (40) @(negedge core_clk_i);
    store(OP3_STS, 5'h4, v[1], 0, 0, 0);
    cmp(5'h1, 5'h2, 9'h0ff);
    finish_test();
  end
endmodule
